// *** pam_map.svh ***
// register offsets, field positions, reset values and timing counts of the alarm manager
`ifndef PAM_MAP_SVH
`define PAM_MAP_SVH
`define PAM_OFF_CTRL   8'h00
`define PAM_OFF_SAFE   8'h04
`define PAM_OFF_LDLY   8'h08
`define PAM_OFF_RMAP   8'h0C
`define PAM_OFF_STAT   8'h10
`define PAM_OFF_ACK    8'h14
`define PAM_OFF_CFG    8'h20
`define PAM_OFF_THR    8'h30
`define PAM_OFF_HYS    8'h40
`define PAM_CFG_TYP    0
`define PAM_CFG_LAT    4
`define PAM_CFG_BLK    6
`define PAM_RST_CTRL   2'h0
`define PAM_RST_CFG    7'h20
`define PAM_RST_LDLY   16'h2710
`define PAM_RST_RMAP   16'h8421
`define PAM_CLK_NS     4
`define PAM_MS_NS      1000000
`define PAM_MS_CYC     ((`PAM_MS_NS + `PAM_CLK_NS - 1) / `PAM_CLK_NS)
`define PAM_RSP_TO_MS  5000
`define PAM_MIN_MS     60000
`define PAM_MSG_MS     1000
`define PAM_FLASH_MS   500
`endif

// *** pam_pkg.sv ***
// types shared by the alarm manager
package pam_pkg;
  typedef enum logic [3:0] {
    PAM_T_NONE = 4'h0, PAM_T_FS_HI = 4'h1, PAM_T_FS_LO = 4'h2,
    PAM_T_DEV_HI = 4'h3, PAM_T_DEV_LO = 4'h4, PAM_T_BAND = 4'h5,
    PAM_T_RATE = 4'h6, PAM_T_OUT_HI = 4'h7, PAM_T_OUT_LO = 4'h8
  } pam_type_e;
  typedef enum logic [1:0] {
    PAM_L_NONE = 2'h0, PAM_L_AUTO = 2'h1, PAM_L_MANUAL = 2'h2, PAM_L_EVENT = 2'h3
  } pam_latch_e;
  typedef struct packed {
    logic       blk;
    pam_latch_e latch;
    pam_type_e  typ;
  } pam_cfg_s;
  typedef struct packed {
    logic       lamp;
    logic       remote_fail;
    logic       loop_break;
    logic       open_input_alarm;
    logic [3:0] acked;
    logic [3:0] active;
  } pam_stat_s;
endpackage

// *** pam_alarm_manager.sv ***
// alarm supervision core with an AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "pam_map.svh"
module pam_alarm_manager
  import pam_pkg::*;
#(
  parameter int MS_CYCLES = `PAM_MS_CYC
) (
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // axi4-lite write channels
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // axi4-lite read channels
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // process side, same clock
  input  wire logic signed [15:0] pv,
  input  wire logic signed [15:0] sp,
  input  wire logic signed [15:0] op_demand,
  input  wire logic               remote_sp_strobe,
  // pins from the field and panel
  input  wire logic [2:0]         wire_open_pin,
  input  wire logic               ack_button_pin,
  // outputs
  output logic signed [15:0]      ctl_out,
  output logic                    alarm_indicator_lamp,
  output logic [3:0]              relay_energised,
  output logic                    msg_valid,
  output logic [2:0]              msg_id,
  output pam_stat_s               status
);
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // configuration registers
  logic [1:0]         in_kind_reg;
  logic [15:0]        safe_reg;
  logic [15:0]        ldly_reg;
  logic [15:0]        rmap_reg;
  pam_cfg_s           cfg_reg [4];
  logic signed [15:0] thr_reg [4];
  logic [15:0]        hys_reg [4];
  logic [3:0]         sw_ack;

  // alarm state
  logic [3:0] cond_reg;
  logic [3:0] blk_reg;
  logic [3:0] act_reg;
  logic [3:0] ackd_reg;
  logic [3:0] eff;
  logic [3:0] trip;
  logic       sb;
  logic       lb_reg;
  logic       rf_reg;

  // axi write side
  logic [7:0]  aw_reg;
  logic        aw_ok;
  logic [31:0] w_reg;
  logic [3:0]  ws_reg;
  logic        w_ok;
  logic        wr_go;
  assign s_axi_awready = !aw_ok;
  assign s_axi_wready = !w_ok;
  assign wr_go = aw_ok && w_ok && !s_axi_bvalid;

  // hold address and data until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok <= 1'b0;
      w_ok <= 1'b0;
      aw_reg <= 8'h00;
      w_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_ok) begin
        aw_ok <= 1'b1;
        aw_reg <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_ok <= 1'b0;
      end
      if (s_axi_wvalid && !w_ok) begin
        w_ok <= 1'b1;
        w_reg <= s_axi_wdata;
        ws_reg <= s_axi_wstrb; // strobes travel with the data, the master may move on
      end else if (wr_go) begin
        w_ok <= 1'b0;
      end
    end
  end

  // write decode and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_kind_reg <= `PAM_RST_CTRL;
      safe_reg <= 16'h0000;
      ldly_reg <= `PAM_RST_LDLY;
      rmap_reg <= `PAM_RST_RMAP;
      sw_ack <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
      for (int i = 0; i < 4; i++) begin
        cfg_reg[i] <= `PAM_RST_CFG;
        thr_reg[i] <= 16'sh0000;
        hys_reg[i] <= 16'h0000;
      end
    end else begin
      sw_ack <= 4'h0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= RESP_OK;
        if (aw_reg[7:2] == `PAM_OFF_CTRL >> 2) begin
          if (ws_reg[0]) in_kind_reg <= w_reg[1:0];
        end else if (aw_reg[7:2] == `PAM_OFF_SAFE >> 2) begin
          if (ws_reg[0]) safe_reg[7:0] <= w_reg[7:0];
          if (ws_reg[1]) safe_reg[15:8] <= w_reg[15:8];
        end else if (aw_reg[7:2] == `PAM_OFF_LDLY >> 2) begin
          if (ws_reg[0]) ldly_reg[7:0] <= w_reg[7:0];
          if (ws_reg[1]) ldly_reg[15:8] <= w_reg[15:8];
        end else if (aw_reg[7:2] == `PAM_OFF_RMAP >> 2) begin
          if (ws_reg[0]) rmap_reg[7:0] <= w_reg[7:0];
          if (ws_reg[1]) rmap_reg[15:8] <= w_reg[15:8];
        end else if (aw_reg[7:2] == `PAM_OFF_STAT >> 2) begin
          s_axi_bresp <= RESP_OK; // read-only, write ignored
        end else if (aw_reg[7:2] == `PAM_OFF_ACK >> 2) begin
          if (ws_reg[0]) sw_ack <= w_reg[3:0];
        end else if (aw_reg[7:4] == `PAM_OFF_CFG >> 4) begin
          if (ws_reg[0]) cfg_reg[aw_reg[3:2]] <= w_reg[6:0];
        end else if (aw_reg[7:4] == `PAM_OFF_THR >> 4) begin
          if (ws_reg[0]) thr_reg[aw_reg[3:2]][7:0] <= w_reg[7:0];
          if (ws_reg[1]) thr_reg[aw_reg[3:2]][15:8] <= w_reg[15:8];
        end else if (aw_reg[7:4] == `PAM_OFF_HYS >> 4) begin
          if (ws_reg[0]) hys_reg[aw_reg[3:2]][7:0] <= w_reg[7:0];
          if (ws_reg[1]) hys_reg[aw_reg[3:2]][15:8] <= w_reg[15:8];
        end else begin
          s_axi_bresp <= RESP_ERR;
        end
      end
    end
  end

  // read decode, answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OK;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OK;
      s_axi_rdata <= 32'h0000_0000;
      if (s_axi_araddr[7:2] == `PAM_OFF_CTRL >> 2) begin
        s_axi_rdata[1:0] <= in_kind_reg;
      end else if (s_axi_araddr[7:2] == `PAM_OFF_SAFE >> 2) begin
        s_axi_rdata[15:0] <= safe_reg;
      end else if (s_axi_araddr[7:2] == `PAM_OFF_LDLY >> 2) begin
        s_axi_rdata[15:0] <= ldly_reg;
      end else if (s_axi_araddr[7:2] == `PAM_OFF_RMAP >> 2) begin
        s_axi_rdata[15:0] <= rmap_reg;
      end else if (s_axi_araddr[7:2] == `PAM_OFF_STAT >> 2) begin
        s_axi_rdata[11:0] <= status;
      end else if (s_axi_araddr[7:2] == `PAM_OFF_ACK >> 2) begin
        s_axi_rdata <= 32'h0000_0000;
      end else if (s_axi_araddr[7:4] == `PAM_OFF_CFG >> 4) begin
        s_axi_rdata[6:0] <= cfg_reg[s_axi_araddr[3:2]];
      end else if (s_axi_araddr[7:4] == `PAM_OFF_THR >> 4) begin
        s_axi_rdata[15:0] <= thr_reg[s_axi_araddr[3:2]];
      end else if (s_axi_araddr[7:4] == `PAM_OFF_HYS >> 4) begin
        s_axi_rdata[15:0] <= hys_reg[s_axi_araddr[3:2]];
      end else begin
        s_axi_rresp <= RESP_ERR;
      end
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // pin synchronisers and panel acknowledge edge
  logic [2:0] wo_m, wo_s;
  logic [2:0] ab_sh;
  logic       panel_ack;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wo_m <= 3'h0;
      wo_s <= 3'h0;
      ab_sh <= 3'h0;
    end else begin
      wo_m <= wire_open_pin;
      wo_s <= wo_m;
      ab_sh <= {ab_sh[1:0], ack_button_pin};
    end
  end
  assign panel_ack = ab_sh[1] && !ab_sh[2];

  // millisecond tick and slower counters
  logic [17:0] ms_cnt;
  logic        ms_tick;
  logic [15:0] min_cnt;
  logic [9:0]  msg_cnt;
  assign ms_tick = ms_cnt == 18'(MS_CYCLES - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_cnt <= 18'h00000;
      min_cnt <= 16'h0000;
      msg_cnt <= 10'h000;
    end else begin
      ms_cnt <= ms_tick ? 18'h00000 : ms_cnt + 18'h00001;
      if (ms_tick) begin
        min_cnt <= (min_cnt == 16'(`PAM_MIN_MS - 1)) ? 16'h0000 : min_cnt + 16'h0001;
        msg_cnt <= (msg_cnt == 10'(`PAM_MSG_MS - 1)) ? 10'h000 : msg_cnt + 10'h001;
      end
    end
  end

  // process value sampled at the start of each minute for the rate alarm
  logic signed [15:0] pv_min_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) pv_min_reg <= 16'sh0000;
    else if (ms_tick && min_cnt == 16'h0000) pv_min_reg <= pv;
  end

  // setpoint change detect
  logic signed [15:0] sp_last;
  logic               sp_chg;
  always_ff @(posedge aclk) begin
    if (!aresetn) sp_last <= 16'sh0000;
    else sp_last <= sp;
  end
  assign sp_chg = sp != sp_last;

  // sensor break by input kind: 0 thermocouple, 1 three-wire, 2 current loop
  always_comb begin
    sb = 1'b0;
    if (in_kind_reg == 2'h0) sb = wo_s[0];
    else if (in_kind_reg == 2'h1) sb = |wo_s;
    else sb = 1'b0;
  end

  // safe level replaces demand on sensor break
  always_ff @(posedge aclk) begin
    if (!aresetn) ctl_out <= 16'sh0000;
    else ctl_out <= sb ? signed'(safe_reg) : op_demand;
  end

  // loop break supervision
  logic signed [15:0] op_last, pv_ref;
  logic [15:0]        lb_cnt;
  logic               lb_run;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_last <= 16'sh0000;
      pv_ref <= 16'sh0000;
      lb_cnt <= 16'h0000;
      lb_run <= 1'b0;
      lb_reg <= 1'b0;
    end else begin
      op_last <= op_demand;
      if (lb_run && pv != pv_ref) begin
        lb_run <= 1'b0;
        lb_reg <= 1'b0;
      end else if (op_demand != op_last && !lb_run) begin
        lb_run <= 1'b1;
        pv_ref <= pv;
        lb_cnt <= 16'h0000;
      end else if (lb_run && ms_tick) begin
        if (lb_cnt >= ldly_reg) lb_reg <= 1'b1;
        else lb_cnt <= lb_cnt + 16'h0001;
      end
    end
  end

  // remote setpoint watchdog
  logic [12:0] rf_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rf_cnt <= 13'h0000;
      rf_reg <= 1'b0;
    end else if (remote_sp_strobe) begin
      rf_cnt <= 13'h0000;
      rf_reg <= 1'b0;
    end else if (ms_tick) begin
      if (rf_cnt == 13'(`PAM_RSP_TO_MS - 1)) rf_reg <= 1'b1;
      else rf_cnt <= rf_cnt + 13'h0001;
    end
  end

  // four general alarms
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_alm
      logic signed [17:0] v, t, h;
      logic               hi_on, hi_off, ack;
      pam_cfg_s           c;
      assign c = cfg_reg[g];
      assign h = 18'(hys_reg[g]);
      assign ack = panel_ack || sw_ack[g];
      // every type folded into a rising compare
      always_comb begin
        v = 18'sh00000;
        t = 18'(thr_reg[g]);
        case (c.typ)
          PAM_T_FS_HI: v = 18'(pv);
          PAM_T_FS_LO: begin
            v = -18'(pv);
            t = -18'(thr_reg[g]);
          end
          PAM_T_DEV_HI: v = 18'(pv) - 18'(sp);
          PAM_T_DEV_LO: v = 18'(sp) - 18'(pv);
          PAM_T_BAND: v = (pv >= sp) ? 18'(pv) - 18'(sp) : 18'(sp) - 18'(pv);
          PAM_T_RATE: v = 18'(pv) - 18'(pv_min_reg);
          PAM_T_OUT_HI: v = 18'(op_demand);
          PAM_T_OUT_LO: begin
            v = -18'(op_demand);
            t = -18'(thr_reg[g]);
          end
          default: v = 18'sh00000;
        endcase
      end
      assign hi_on = v > t;
      assign hi_off = v < t - h;
      // hysteresis-held condition and blocking
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cond_reg[g] <= 1'b0;
          blk_reg[g] <= 1'b1;
        end else begin
          if (c.typ == PAM_T_NONE) cond_reg[g] <= 1'b0;
          else if (hi_on) cond_reg[g] <= 1'b1;
          else if (hi_off) cond_reg[g] <= 1'b0;
          if (sp_chg) blk_reg[g] <= 1'b1;
          else if (!cond_reg[g]) blk_reg[g] <= 1'b0;
        end
      end
      assign eff[g] = cond_reg[g] && !(c.blk && blk_reg[g]);
      // latching and acknowledge
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          act_reg[g] <= 1'b0;
          ackd_reg[g] <= 1'b0;
        end else if (eff[g]) begin
          act_reg[g] <= 1'b1;
          if (ack && act_reg[g] && c.latch != PAM_L_MANUAL) ackd_reg[g] <= 1'b1;
        end else begin
          case (c.latch)
            PAM_L_NONE, PAM_L_EVENT: begin
              act_reg[g] <= 1'b0;
              ackd_reg[g] <= 1'b0;
            end
            PAM_L_AUTO: begin
              if (ackd_reg[g] || ack) begin
                act_reg[g] <= 1'b0;
                ackd_reg[g] <= 1'b0;
              end
            end
            default: begin
              if (ack) begin
                act_reg[g] <= 1'b0;
                ackd_reg[g] <= 1'b0;
              end
            end
          endcase
        end
      end
      // relay trips while the alarm is active and unacknowledged; events follow the condition
      assign trip[g] = (c.latch == PAM_L_EVENT) ? eff[g] : act_reg[g] && !ackd_reg[g];
    end
  endgenerate

  // relay outputs, each from any group of alarms
  generate
    for (g = 0; g < 4; g++) begin : g_rly
      always_ff @(posedge aclk) begin
        if (!aresetn) relay_energised[g] <= 1'b1;
        else relay_energised[g] <= !(|(rmap_reg[4*g +: 4] & trip));
      end
    end
  endgenerate

  // lamp: flash on unacknowledged, steady on acknowledged, dark for events
  logic [3:0] lit, unack;
  logic       lamp_req, lamp_flash;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lit[i] = act_reg[i] && cfg_reg[i].latch != PAM_L_EVENT;
      unack[i] = lit[i] && !ackd_reg[i];
    end
  end
  assign lamp_req = |lit || sb || lb_reg || rf_reg;
  assign lamp_flash = |unack || sb || lb_reg || rf_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) alarm_indicator_lamp <= 1'b0;
    else if (lamp_flash) alarm_indicator_lamp <= msg_cnt < 10'(`PAM_FLASH_MS);
    else alarm_indicator_lamp <= lamp_req;
  end

  // message scroller over present sources 0..3 alarms, 4 open input, 5 loop, 6 remote
  logic [6:0] src;
  logic [2:0] nxt;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      src[i] = (cfg_reg[i].latch == PAM_L_EVENT) ? eff[i] : act_reg[i];
    end
    src[4] = sb;
    src[5] = lb_reg;
    src[6] = rf_reg;
    nxt = msg_id;
    for (int k = 7; k >= 1; k--) begin
      if (src[(32'(msg_id) + k) % 7]) nxt = 3'((32'(msg_id) + k) % 7);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msg_id <= 3'h0;
      msg_valid <= 1'b0;
    end else begin
      msg_valid <= |src;
      if (!src[msg_id] || (ms_tick && msg_cnt == 10'h000)) msg_id <= nxt;
    end
  end

  // status word
  always_ff @(posedge aclk) begin
    if (!aresetn) status <= '0;
    else status <= {alarm_indicator_lamp, rf_reg, lb_reg, sb, ackd_reg, act_reg};
  end
endmodule

// *** pam_field_model.sv ***
// sensor wiring and panel button model facing the alarm manager
`timescale 1ns/1ps
module pam_field_model (
  // clock
  input  wire logic       aclk,
  // bench commands
  input  wire logic [2:0] open_cmd,
  input  wire logic       press_cmd,
  // field and panel pins
  output logic      [2:0] wire_open_pin,
  output logic            ack_button_pin
);
  logic [2:0] hold_reg = 3'h0; // button starts released, the model has no reset
  // broken wires show at once, without regard to the clock
  assign wire_open_pin = open_cmd;
  // a press keeps the contact closed for several cycles, like a finger
  always_ff @(posedge aclk) begin
    if (press_cmd) hold_reg <= 3'h6;
    else if (hold_reg != 3'h0) hold_reg <= hold_reg - 3'h1;
  end
  assign ack_button_pin = (hold_reg != 3'h0);
endmodule

// *** pam_alarm_manager_checker.sv ***
// port assertions for the alarm manager
`timescale 1ns/1ps
module pam_alarm_manager_checker
  import pam_pkg::*;
(
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // bus handshakes
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  // field and outputs
  input wire logic [2:0] wire_open_pin,
  input wire logic       alarm_indicator_lamp,
  input wire logic [3:0] relay_energised,
  input wire logic       msg_valid,
  input wire pam_stat_s  status
);
  logic [3:0] quiet_reg;
  logic       idle;
  // cycles since every sensor wire read closed
  always_ff @(posedge aclk) begin
    if (!aresetn) quiet_reg <= 4'h0;
    else if (wire_open_pin != 3'h0) quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hF) quiet_reg <= quiet_reg + 4'h1;
  end
  // nothing present anywhere
  assign idle = (status.active == 4'h0) && !status.open_input_alarm
                && !status.loop_break && !status.remote_fail;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reset_relays_a: assert property ($rose(aresetn) |-> relay_energised == 4'hF)
    else $error("relays not energised after reset");
  // events trip relays and messages a cycle before status shows them
  relay_idle_a: assert property (status.active == 4'h0 ##1 status.active == 4'h0
    |-> $past(relay_energised) == 4'hF)
    else $error("relay tripped with no alarm");
  lamp_dark_a: assert property (idle |-> !alarm_indicator_lamp)
    else $error("lamp lit with nothing present");
  msg_idle_a: assert property (idle ##1 idle |-> !$past(msg_valid))
    else $error("message shown with nothing present");
  wires_closed_a: assert property (quiet_reg >= 4'h8 |-> !status.open_input_alarm)
    else $error("open input alarm with wires closed");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
endmodule
bind pam_alarm_manager pam_alarm_manager_checker chk_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .wire_open_pin,
  .alarm_indicator_lamp, .relay_energised, .msg_valid, .status);

// *** pam_alarm_manager_bench.sv ***
// self-checking bench for the alarm manager
`timescale 1ns/1ps
module pam_alarm_manager_bench
  import pam_pkg::*;
;
  logic               aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, strobe, press;
  logic [7:0]         awaddr, araddr;
  logic [31:0]        wdata, rd;
  logic [1:0]         rs;
  logic [2:0]         open_cmd, wop, msg_id;
  logic signed [15:0] pv, sp, opd, ctl_out;
  logic               awready, wready, bvalid, arready, rvalid, ackp, lamp, msg_valid;
  logic [1:0]         bresp, rresp;
  logic [31:0]        rdata;
  logic [3:0]         relay;
  pam_stat_s          status;
  int                 fails, checks_done, cyc, hi;
  pam_alarm_manager #(.MS_CYCLES(4)) dut (.aclk, .aresetn, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pv, .sp,
    .op_demand(opd), .remote_sp_strobe(strobe), .wire_open_pin(wop), .ack_button_pin(ackp),
    .ctl_out, .alarm_indicator_lamp(lamp), .relay_energised(relay), .msg_valid, .msg_id,
    .status);
  pam_field_model fld (.aclk, .open_cmd, .press_cmd(press), .wire_open_pin(wop),
    .ack_button_pin(ackp));
  // clock, 4 ns period
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // one bus write, response code compared
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk(bresp, e);
  endtask
  // one bus read into rd and rs
  task automatic rdr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
  endtask
  task automatic ack_panel();
    press <= 1'b1;
    tick(1);
    press <= 1'b0;
    tick(12);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, press, awaddr, araddr, wdata} = '0;
    {pv, sp, opd, open_cmd, fails, checks_done, cyc} = '0;
    strobe = 1'b1;
    aresetn = 1'b0;
    tick(2);
    aresetn <= 1'b1;
    // reset values and unmapped places
    rdr(8'h08); chk(rd, 32'h2710);
    rdr(8'h0C); chk(rd, 32'h8421);
    rdr(8'h20); chk(rd, 32'h20);
    rdr(8'hFC); chk({rs, rd}, {2'h2, 32'h0});
    wr(8'hFC, 32'h1, 2'h2);
    $display("test registers done");
    // manual latch with hysteresis
    wr(8'h30, 32'd100); wr(8'h40, 32'd10); wr(8'h20, 32'h21);
    pv <= 16'sd150; tick(5); chk({status.active[0], relay}, 5'h1E);
    ack_panel(); pv <= 16'sd95; tick(5); ack_panel(); chk(status.active[0], 1'b1);
    pv <= 16'sd80; tick(5); chk(status.active[0], 1'b1);
    ack_panel(); tick(3); chk({status.active[0], relay}, 5'h0F);
    $display("test manual done");
    // auto latch on output high, early acknowledge
    wr(8'h20, 32'h17); opd <= 16'sd200; tick(5); chk(status.active[0], 1'b1);
    wr(8'h14, 32'h1); tick(4); chk({status.acked[0], lamp}, 2'h3);
    opd <= 16'sd0; tick(5); chk(status.active[0], 1'b0);
    $display("test auto done");
    // no latch on output low
    wr(8'h20, 32'h08); opd <= -16'sd50; tick(5); chk(status.active[0], 1'b1);
    ack_panel(); chk({status.active[0], lamp, msg_valid}, 3'h7);
    opd <= 16'sd150; tick(5); chk({status.active[0], lamp, msg_valid}, 3'h0);
    opd <= -16'sd50; tick(5); opd <= 16'sd150; tick(5); chk(status.active[0], 1'b0);
    $display("test unlatched done");
    // event on alarm 1, shared relay
    wr(8'h20, 32'h0); wr(8'h0C, 32'h3); wr(8'h34, 32'h0); wr(8'h24, 32'h32);
    pv <= -16'sd10; tick(5);
    chk({lamp, relay, msg_valid, msg_id}, {1'b0, 4'hE, 1'b1, 3'h1});
    wr(8'h24, 32'h0); pv <= 16'sd50; tick(5); chk(relay, 4'hF);
    $display("test event done");
    // blocking after a setpoint change, held until the condition clears
    pv <= 16'sd150; wr(8'h20, 32'h41); sp <= 16'sd1; tick(5);
    chk(status.active[0], 1'b0);
    tick(20); chk(status.active[0], 1'b0);
    pv <= 16'sd50; tick(5); pv <= 16'sd150; tick(5); chk(status.active[0], 1'b1);
    sp <= 16'sd2; tick(5); chk(status.active[0], 1'b0);
    wr(8'h20, 32'h0); pv <= 16'sd50; tick(5);
    $display("test blocking done");
    // deviation band, then rise against the value held since just after reset
    wr(8'h20, 32'h05); pv <= -16'sd150; tick(5); chk(status.active[0], 1'b1);
    wr(8'h20, 32'h06); tick(5); chk(status.active[0], 1'b0);
    pv <= 16'sd150; tick(5); chk(status.active[0], 1'b1);
    wr(8'h20, 32'h0); pv <= 16'sd50; tick(5);
    $display("test rate done");
    // sensor break per input kind
    wr(8'h04, 32'h0123); wr(8'h00, 32'h0); open_cmd <= 3'h1; tick(8);
    chk({status.open_input_alarm, ctl_out}, {1'b1, 16'h0123});
    open_cmd <= 3'h0; wr(8'h00, 32'h2); open_cmd <= 3'h7; tick(8);
    chk(status.open_input_alarm, 1'b0);
    open_cmd <= 3'h0; wr(8'h00, 32'h1); open_cmd <= 3'h4; tick(8);
    chk(status.open_input_alarm, 1'b1);
    open_cmd <= 3'h0; tick(8);
    $display("test sensor done");
    // loop break with a 10 ms delay
    wr(8'h08, 32'd10); opd <= 16'sd70; tick(30); chk(status.loop_break, 1'b0);
    tick(30); chk(status.loop_break, 1'b1);
    pv <= 16'sd51; tick(5); chk(status.loop_break, 1'b0);
    $display("test loop done");
    // remote setpoint watchdog, then lamp flashing
    strobe <= 1'b0; tick(19980); chk(status.remote_fail, 1'b0);
    tick(40); chk({status.remote_fail, msg_valid, msg_id}, 5'h1E);
    rdr(8'h10); chk(rd[10], 1'b1);
    hi = 0;
    repeat (4000) begin
      @(posedge aclk);
      hi += int'(lamp === 1'b1);
    end
    chk(hi inside {[1900:2100]}, 1'b1);
    $display("test remote done");
    finish_test();
  end
endmodule
